// >>> alm_fault_if.sv
`timescale 1ns/10ps
interface alm_fault_if;
  logic [alm_pkg::FLAG_N-1:0] level;
  logic [alm_pkg::FLAG_N-1:0] rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface : alm_fault_if

// >>> alm_fault_sync.sv
`timescale 1ns/10ps
module alm_fault_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Raw fault pins
  input wire logic [alm_pkg::FLAG_N-1:0] raw,
  // Conditioned flags
  alm_fault_if.src flt
);

  logic [alm_pkg::FLAG_N-1:0] s1;
  logic [alm_pkg::FLAG_N-1:0] s2;
  logic [alm_pkg::FLAG_N-1:0] s3;
  logic [alm_pkg::FLAG_N-1:0] next_s1;
  logic [alm_pkg::FLAG_N-1:0] next_s2;
  logic [alm_pkg::FLAG_N-1:0] next_s3;

  // First stage feeds only the second
  always_comb begin
    next_s1 = raw;
    next_s2 = s1;
    next_s3 = s2;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
    end
  end

  assign flt.level = s2;
  assign flt.rise = s2 & ~s3;

endmodule : alm_fault_sync

// >>> alm_host.sv
`timescale 1ns/10ps
module alm_host (
  // Clock
  input wire logic clk,
  // Write side
  output logic [9:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // Read side
  output logic [9:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // Payload inverted once taken so stale values cannot pass
  task automatic wr(input logic [9:0] a, input logic [15:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~{16'h0000, d};
      end
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : alm_host

// >>> alm_pkg.sv
package alm_pkg;

  // Register width and word indices; byte address is four times the index
  localparam int REG_W = 16;
  localparam int IDX_W = 8;
  localparam logic [7:0] IDX_MASK = 8'h0c;
  localparam logic [7:0] IDX_ACTION = 8'h0d;
  localparam logic [7:0] IDX_CODE = 8'h0e;
  localparam logic [7:0] IDX_RSVD = 8'h0f;
  localparam logic [7:0] IDX_EVENT = 8'h20;
  localparam logic [7:0] IDX_EVMASK = 8'h21;
  localparam logic [7:0] IDX_STATE = 8'h22;
  localparam logic [7:0] IDX_RELEASE = 8'h23;

  // Reset values
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] ACTION_RST = 16'h0000;
  localparam logic [15:0] CODE_RST = 16'h0000;

  // Mask bit positions; the state register holds the status flags at bits 12:8 instead
  localparam int BIT_WDT = 11;
  localparam int BIT_CRE = 5;
  localparam int BIT_TMP = 4;
  localparam int BIT_OUT = 0;

  // Action field positions
  localparam int ACT_CW_LSB = 6;
  localparam int ACT_IOC_LSB = 4;
  localparam int ACT_VSC_LSB = 2;
  localparam int ACT_TMP_LSB = 0;

  // Fallback code and clamp select
  localparam int CODE_LSB = 10;
  localparam int CODE_W = 6;
  localparam int CLAMP_BIT = 9;

  // Fault condition index, also event bit index
  localparam int FLAG_N = 5;
  localparam int FL_WDT = 0;
  localparam int FL_CRE = 1;
  localparam int FL_TMP = 2;
  localparam int FL_IOC = 3;
  localparam int FL_VSC = 4;
  localparam int EV_SHUT = 5;
  localparam int EV_W = 6;

  // State register layout and release bit
  localparam int ST_SHUT = 0;
  localparam int ST_OVR = 1;
  localparam int ST_ALARM = 2;
  localparam int ST_FLAG_LSB = 8;
  localparam int RELEASE_BIT = 0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_CODE = 2'h1,
    ACT_SHUT = 2'h2,
    ACT_BAD = 2'h3
  } alm_action_e;

  typedef enum logic [1:0] {
    PS_RUN = 2'h0,
    PS_OVERRIDE = 2'h1,
    PS_SHUTDOWN = 2'h3
  } alm_prot_e;

endpackage : alm_pkg

// >>> alm_regs.sv
// Functional notes
// - Mask bit 11 blocks watchdog fault alarm
// - Mask bit 5 blocks checksum error alarm
// - Mask bit 4 blocks overtemperature alarm
// - Mask bit 0 blocks output fault alarm
// - Bits 7:6 act on checksum/watchdog faults
// - Bits 5:4 act on open circuit
// - Bits 3:2 act on short circuit
// - Bits 1:0 act on overtemperature
// - Shutdown stays latched after condition clears
// - Six-bit fallback code in bits 15:10
// - Bit 9 selects 26 V clamp, else 32 V
// - Index 0x0F reserved, read-only
// - Reset clears mask, action, code registers
// - Status flags share mask bit positions; the state register places them at bits 12:8 instead
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module alm_regs #(
  parameter int ADDR_W = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Fault condition pins
  input wire logic watchdog_fault,
  input wire logic checksum_error,
  input wire logic overtemp,
  input wire logic open_circuit,
  input wire logic short_circuit,
  // Alarm and protection outputs
  output logic alarm,
  output logic converter_enable,
  output logic dac_output_enable,
  output logic code_override,
  output logic [alm_pkg::CODE_W-1:0] fallback_output_code,
  output logic positive_high_clamp_select,
  output logic irq
);

  if (ADDR_W < alm_pkg::IDX_W + 2 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must hold every register index");
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction : hit

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    merge = old;
    if (s[0]) begin
      merge[7:0] = d[7:0];
    end
    if (s[1]) begin
      merge[15:8] = d[15:8];
    end
  endfunction : merge

  function automatic alm_pkg::alm_action_e field(input logic [15:0] r,
                                                 input int lsb);
    field = alm_pkg::alm_action_e'(r[lsb +: 2]);
  endfunction : field

  // Synchronised fault conditions
  alm_fault_if flt ();

  alm_fault_sync u_sync (
    .clk(clk),
    .reset(reset),
    .raw({short_circuit, open_circuit, overtemp, checksum_error, watchdog_fault}),
    .flt(flt)
  );

  logic [15:0] alarm_pin_mask;
  logic [15:0] alarm_response_select;
  logic [15:0] fallback_code_and_clamp;
  logic [alm_pkg::EV_W-1:0] event_status;
  logic [alm_pkg::EV_W-1:0] event_mask;
  alm_pkg::alm_prot_e prot_state;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  logic [15:0] next_alarm_pin_mask;
  logic [15:0] next_alarm_response_select;
  logic [15:0] next_fallback_code_and_clamp;
  logic [alm_pkg::EV_W-1:0] next_event_status;
  logic [alm_pkg::EV_W-1:0] next_event_mask;
  alm_pkg::alm_prot_e next_prot_state;
  logic next_aw_held;
  logic next_w_held;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic next_alarm;
  logic next_converter_enable;
  logic next_dac_output_enable;
  logic next_code_override;
  logic [alm_pkg::CODE_W-1:0] next_fallback_output_code;
  logic next_positive_high_clamp_select;
  logic next_irq;

  logic wr_go;
  logic rd_go;
  logic release_req;
  logic ev_clear;
  logic output_fault_flag;
  logic cw_cond;
  logic shut_req;
  logic code_req;
  logic [alm_pkg::EV_W-1:0] ev_set;

  // Bus handshake and register access
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    // Ready rises one edge after reset release
    next_arready = s_axi_arready || !s_axi_rvalid;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_alarm_pin_mask = alarm_pin_mask;
    next_alarm_response_select = alarm_response_select;
    next_fallback_code_and_clamp = fallback_code_and_clamp;
    next_event_mask = event_mask;
    release_req = 1'b0;
    ev_clear = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    wr_go = aw_held && w_held && !s_axi_bvalid;
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = alm_pkg::RESP_OKAY;
      if (hit(aw_addr, alm_pkg::IDX_MASK)) begin
        next_alarm_pin_mask = merge(alarm_pin_mask, w_data, w_strb);
      end else if (hit(aw_addr, alm_pkg::IDX_ACTION)) begin
        next_alarm_response_select = merge(alarm_response_select, w_data, w_strb);
      end else if (hit(aw_addr, alm_pkg::IDX_CODE)) begin
        next_fallback_code_and_clamp = merge(fallback_code_and_clamp, w_data, w_strb);
      end else if (hit(aw_addr, alm_pkg::IDX_RSVD)) begin
        next_bresp = alm_pkg::RESP_OKAY;
      end else if (hit(aw_addr, alm_pkg::IDX_EVMASK)) begin
        if (w_strb[0]) begin
          next_event_mask = w_data[alm_pkg::EV_W-1:0];
        end
      end else if (hit(aw_addr, alm_pkg::IDX_RELEASE)) begin
        release_req = w_strb[0] && w_data[alm_pkg::RELEASE_BIT];
      end else if (hit(aw_addr, alm_pkg::IDX_EVENT) || hit(aw_addr, alm_pkg::IDX_STATE)) begin
        next_bresp = alm_pkg::RESP_OKAY;
      end else begin
        next_bresp = alm_pkg::RESP_SLVERR;
      end
    end
    // One read at a time; address refused while data is pending
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
    rd_go = s_axi_arvalid && s_axi_arready;
    if (rd_go) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = '0;
      next_rresp = alm_pkg::RESP_OKAY;
      if (hit(s_axi_araddr, alm_pkg::IDX_MASK)) begin
        next_rdata[15:0] = alarm_pin_mask;
      end else if (hit(s_axi_araddr, alm_pkg::IDX_ACTION)) begin
        next_rdata[15:0] = alarm_response_select;
      end else if (hit(s_axi_araddr, alm_pkg::IDX_CODE)) begin
        next_rdata[15:0] = fallback_code_and_clamp;
      end else if (hit(s_axi_araddr, alm_pkg::IDX_RSVD)) begin
        next_rdata = '0;
      end else if (hit(s_axi_araddr, alm_pkg::IDX_EVENT)) begin
        next_rdata[alm_pkg::EV_W-1:0] = event_status;
        ev_clear = 1'b1;
      end else if (hit(s_axi_araddr, alm_pkg::IDX_EVMASK)) begin
        next_rdata[alm_pkg::EV_W-1:0] = event_mask;
      end else if (hit(s_axi_araddr, alm_pkg::IDX_STATE)) begin
        next_rdata[alm_pkg::ST_SHUT] = (prot_state == alm_pkg::PS_SHUTDOWN);
        next_rdata[alm_pkg::ST_OVR] = (prot_state == alm_pkg::PS_OVERRIDE);
        next_rdata[alm_pkg::ST_ALARM] = alarm;
        next_rdata[alm_pkg::ST_FLAG_LSB +: alm_pkg::FLAG_N] = flt.level;
      end else if (hit(s_axi_araddr, alm_pkg::IDX_RELEASE)) begin
        next_rdata = '0;
      end else begin
        next_rresp = alm_pkg::RESP_SLVERR;
      end
    end
    next_awready = !next_aw_held;
    next_wready = !next_w_held;
  end

  // Alarm pin, safe actions and events
  always_comb begin
    output_fault_flag = flt.level[alm_pkg::FL_IOC] | flt.level[alm_pkg::FL_VSC];
    next_alarm =
      (flt.level[alm_pkg::FL_WDT] & ~alarm_pin_mask[alm_pkg::BIT_WDT]) |
      (flt.level[alm_pkg::FL_CRE] & ~alarm_pin_mask[alm_pkg::BIT_CRE]) |
      (flt.level[alm_pkg::FL_TMP] & ~alarm_pin_mask[alm_pkg::BIT_TMP]) |
      (output_fault_flag & ~alarm_pin_mask[alm_pkg::BIT_OUT]);
    cw_cond = flt.level[alm_pkg::FL_WDT] | flt.level[alm_pkg::FL_CRE];
    // Code 11 acts like code 00
    shut_req =
      (cw_cond && field(alarm_response_select, alm_pkg::ACT_CW_LSB) == alm_pkg::ACT_SHUT) ||
      (flt.level[alm_pkg::FL_IOC] &&
       field(alarm_response_select, alm_pkg::ACT_IOC_LSB) == alm_pkg::ACT_SHUT) ||
      (flt.level[alm_pkg::FL_VSC] &&
       field(alarm_response_select, alm_pkg::ACT_VSC_LSB) == alm_pkg::ACT_SHUT) ||
      (flt.level[alm_pkg::FL_TMP] &&
       field(alarm_response_select, alm_pkg::ACT_TMP_LSB) == alm_pkg::ACT_SHUT);
    // Single output channel: all outputs and alarming outputs coincide
    code_req =
      (cw_cond && field(alarm_response_select, alm_pkg::ACT_CW_LSB) == alm_pkg::ACT_CODE) ||
      (flt.level[alm_pkg::FL_IOC] &&
       field(alarm_response_select, alm_pkg::ACT_IOC_LSB) == alm_pkg::ACT_CODE) ||
      (flt.level[alm_pkg::FL_VSC] &&
       field(alarm_response_select, alm_pkg::ACT_VSC_LSB) == alm_pkg::ACT_CODE) ||
      (flt.level[alm_pkg::FL_TMP] &&
       field(alarm_response_select, alm_pkg::ACT_TMP_LSB) == alm_pkg::ACT_CODE);
    next_prot_state = prot_state;
    case (prot_state)
      alm_pkg::PS_SHUTDOWN: begin
        // Only an explicit release with no live shutdown cause leaves here
        if (release_req && !shut_req) begin
          next_prot_state = code_req ? alm_pkg::PS_OVERRIDE : alm_pkg::PS_RUN;
        end
      end
      default: begin
        if (shut_req) begin
          next_prot_state = alm_pkg::PS_SHUTDOWN;
        end else if (code_req) begin
          next_prot_state = alm_pkg::PS_OVERRIDE;
        end else begin
          next_prot_state = alm_pkg::PS_RUN;
        end
      end
    endcase
    next_converter_enable = (next_prot_state != alm_pkg::PS_SHUTDOWN);
    next_dac_output_enable = (next_prot_state != alm_pkg::PS_SHUTDOWN);
    next_code_override = (next_prot_state == alm_pkg::PS_OVERRIDE);
    next_fallback_output_code =
      fallback_code_and_clamp[alm_pkg::CODE_LSB +: alm_pkg::CODE_W];
    next_positive_high_clamp_select = fallback_code_and_clamp[alm_pkg::CLAMP_BIT];
    ev_set = '0;
    ev_set[alm_pkg::FLAG_N-1:0] = flt.rise;
    ev_set[alm_pkg::EV_SHUT] = (prot_state != alm_pkg::PS_SHUTDOWN) &&
                               (next_prot_state == alm_pkg::PS_SHUTDOWN);
    // A new event in the clearing read cycle survives
    next_event_status = (ev_clear ? '0 : event_status) | ev_set;
    next_irq = |(next_event_status & next_event_mask);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      alarm_pin_mask <= alm_pkg::MASK_RST;
      alarm_response_select <= alm_pkg::ACTION_RST;
      fallback_code_and_clamp <= alm_pkg::CODE_RST;
      event_status <= '0;
      event_mask <= '0;
      prot_state <= alm_pkg::PS_RUN;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= alm_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= alm_pkg::RESP_OKAY;
      alarm <= 1'b0;
      converter_enable <= 1'b1;
      dac_output_enable <= 1'b1;
      code_override <= 1'b0;
      fallback_output_code <= '0;
      positive_high_clamp_select <= 1'b0;
      irq <= 1'b0;
    end else begin
      alarm_pin_mask <= next_alarm_pin_mask;
      alarm_response_select <= next_alarm_response_select;
      fallback_code_and_clamp <= next_fallback_code_and_clamp;
      event_status <= next_event_status;
      event_mask <= next_event_mask;
      prot_state <= next_prot_state;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      alarm <= next_alarm;
      converter_enable <= next_converter_enable;
      dac_output_enable <= next_dac_output_enable;
      code_override <= next_code_override;
      fallback_output_code <= next_fallback_output_code;
      positive_high_clamp_select <= next_positive_high_clamp_select;
      irq <= next_irq;
    end
  end

endmodule : alm_regs

// >>> alm_regs_bench.sv
`timescale 1ns/10ps
module alm_regs_bench;
  typedef struct {
    logic [9:0] addr;
    logic [15:0] wdat;
    logic [15:0] rexp;
    logic [1:0] resp;
  } alm_row_s;
  logic clk;
  logic reset;
  logic [9:0] s_axi_awaddr;
  logic [9:0] s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp;
  logic [1:0] s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic watchdog_fault, checksum_error, overtemp, open_circuit, short_circuit;
  logic alarm, converter_enable, dac_output_enable, code_override, positive_high_clamp_select, irq;
  logic [5:0] fallback_output_code;
  logic [4:0] pins;
  logic [31:0] d;
  logic [1:0] r;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  int fl[5] = '{alm_pkg::FL_WDT, alm_pkg::FL_CRE, alm_pkg::FL_TMP, alm_pkg::FL_IOC, alm_pkg::FL_VSC};
  int mb[5] = '{11, 5, 4, 0, 0};
  int al[5] = '{6, 6, 0, 4, 2};
  alm_row_s rows[5] = '{
    '{10'h030, 16'hffff, 16'hffff, 2'h0},
    '{10'h034, 16'h5555, 16'h5555, 2'h0},
    '{10'h038, 16'hfe00, 16'hfe00, 2'h0},
    '{10'h03c, 16'hffff, 16'h0000, 2'h0},
    '{10'h3fc, 16'h1234, 16'h0000, 2'h2}
  };
  assign watchdog_fault = pins[alm_pkg::FL_WDT];
  assign checksum_error = pins[alm_pkg::FL_CRE];
  assign overtemp = pins[alm_pkg::FL_TMP];
  assign open_circuit = pins[alm_pkg::FL_IOC];
  assign short_circuit = pins[alm_pkg::FL_VSC];
  alm_regs i_dut (.*);
  alm_host i_host (.*);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : check
  // Fixed wait covers sync and output register latency
  task automatic fault(input int i, input logic v);
    @(posedge clk);
    pins[i] <= v;
    repeat (5) @(posedge clk);
  endtask : fault
  task automatic results;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      results();
    end
  end
  initial begin
    reset = 1'b1;
    pins = '0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      i_host.wr(rows[i].addr, rows[i].wdat, r);
      check(r === rows[i].resp, "write response");
      i_host.rd(rows[i].addr, d, r);
      check(r === rows[i].resp && (r !== 2'h0 || d === {16'h0000, rows[i].rexp}), "read back");
    end
    repeat (2) @(posedge clk);
    check(fallback_output_code === 6'h3f && positive_high_clamp_select === 1'b1, "code outputs");
    reset <= 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    check(fallback_output_code === 6'h00 && positive_high_clamp_select === 1'b0, "reset outputs");
    for (int a = 12; a < 15; a++) begin
      i_host.rd(10'(a * 4), d, r);
      check(d === 32'h0000_0000 && r === 2'h0, "reset value");
    end
    i_host.wr(10'h038, 16'ha400, r);
    for (int k = 0; k < 5; k++) begin
      for (int m = 0; m < 2; m++) begin
        i_host.wr(10'h030, 16'(m) << mb[k], r);
        fault(fl[k], 1'b1);
        check(alarm === (m == 0), "alarm gate");
        fault(fl[k], 1'b0);
        check(alarm === 1'b0, "alarm idle");
      end
      for (int c = 1; c < 3; c++) begin
        i_host.wr(10'h034, 16'(c) << al[k], r);
        fault(fl[k], 1'b1);
        check(code_override === (c == 1) && converter_enable === (c == 1)
          && fallback_output_code === 6'h29, "action");
        fault(fl[k], 1'b0);
        check(converter_enable === (c == 1) && dac_output_enable === (c == 1), "latched");
        i_host.wr(10'h08c, 16'h0001, r);
        repeat (2) @(posedge clk);
        check(converter_enable === 1'b1, "released");
      end
      // Shared checksum/watchdog field must not act in the next mask pass
      i_host.wr(10'h034, 16'h0000, r);
    end
    i_host.wr(10'h084, 16'h0004, r);
    i_host.rd(10'h080, d, r);
    fault(alm_pkg::FL_TMP, 1'b1);
    check(irq === 1'b1, "irq raised");
    i_host.rd(10'h080, d, r);
    check(d === 32'h0000_0004, "event status");
    @(posedge clk);
    check(irq === 1'b0, "irq cleared");
    fault(alm_pkg::FL_TMP, 1'b0);
    i_host.wr(10'h084, 16'h0000, r);
    fault(alm_pkg::FL_TMP, 1'b1);
    check(irq === 1'b0, "irq masked");
    results();
  end
endmodule : alm_regs_bench

// >>> alm_regs_properties.sv
`timescale 1ns/10ps
module alm_regs_properties #(
  parameter int ADDR_W = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bus signals watched
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  // Fault pins
  input wire logic watchdog_fault,
  input wire logic checksum_error,
  input wire logic overtemp,
  input wire logic open_circuit,
  input wire logic short_circuit,
  // Alarm and protection outputs
  input wire logic alarm,
  input wire logic converter_enable,
  input wire logic dac_output_enable,
  input wire logic code_override,
  input wire logic [alm_pkg::CODE_W-1:0] fallback_output_code,
  input wire logic positive_high_clamp_select,
  input wire logic irq
);
  logic [4:0] hist;
  // Pin history covers the two-stage sync plus output register
  always_ff @(posedge clk) begin
    hist <= {hist[3:0], watchdog_fault | checksum_error | overtemp | open_circuit | short_circuit};
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_reset_clears: assert property (disable iff (1'b0) reset |=> fallback_output_code == 6'h00
    && !positive_high_clamp_select && converter_enable && !alarm && !code_override && !irq)
    else $error("outputs not cleared by reset");
  a_alarm_cause: assert property (alarm |-> |hist[4:1])
    else $error("alarm without active condition");
  a_shut_cause: assert property ($fell(converter_enable) |-> |hist[4:1])
    else $error("shutdown without fault");
  a_override_cause: assert property ($rose(code_override) |-> |hist[4:1] || $past(s_axi_bvalid))
    else $error("override without fault");
  a_shut_latched: assert property ($rose(converter_enable) |-> s_axi_bvalid)
    else $error("shutdown left without release write");
  a_enables_pair: assert property (converter_enable == dac_output_enable)
    else $error("converter and output enables differ");
  a_rsvd_reads: assert property (s_axi_arvalid && s_axi_arready
    && (s_axi_araddr >> 2) == ADDR_W'(alm_pkg::IDX_RSVD)
    |-> ##[1:2] s_axi_rvalid && s_axi_rdata == 32'h0000_0000 && s_axi_rresp == alm_pkg::RESP_OKAY)
    else $error("reserved word read wrong");
  a_code_by_write: assert property ($changed(fallback_output_code)
    || $changed(positive_high_clamp_select) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("code or clamp changed without write");
  c_shutdown: cover property ($fell(converter_enable));
  c_override: cover property ($rose(code_override));
  c_irq: cover property ($rose(irq));
endmodule : alm_regs_properties

bind alm_regs alm_regs_properties #(.ADDR_W(ADDR_W)) i_props (.*);
